/* File: pkg/tw_pkg.sv */
// Shared constants, types and size helpers for the two-wire memory target
package tw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int WRITE_TIME_MS  = 5;
  // Longest time: rounds down
  localparam int WR_CYCLES      = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GLITCH_TIME_NS = 8;
  // Least time: rounds up
  localparam int FILT_CYCLES    = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W         = 21;
  localparam int FILT_W         = 4;

  // ----------------------------------------------------------------
  // Protocol fields and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam int         ADDR_W        = 11;
  localparam int         MEM_BYTES     = 2048;
  localparam int         PAGE_MAX      = 16;
  localparam int         FIFO_DEPTH    = 2;
  localparam int         SIZE_1K       = 0;
  localparam int         SIZE_2K       = 1;
  localparam int         SIZE_4K       = 2;
  localparam int         SIZE_8K       = 3;
  localparam int         SIZE_16K      = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_READ} tw_state_t;

  // Selection bits taken over as page bits
  function automatic int twPageBits(input int code);
    return (code < SIZE_4K) ? 0 : code - 1;
  endfunction

  // Word address width of the array
  function automatic int twAddrBits(input int code);
    return 7 + code;
  endfunction

  // Address bits that advance within one page
  function automatic int twLowBits(input int code);
    return (code < SIZE_4K) ? 3 : 4;
  endfunction

endpackage

/* File: hdl/tw_pin_filter.sv */
// Two-flop synchroniser and stability filter for one serial pin
`timescale 1ns/1ps
module tw_pin_filter
  import tw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      pinOut_q
);

  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);

  logic              sync1_q;
  logic              sync2_q;
  logic [FILT_W-1:0] stableCnt_q;

  // ----------------------------------------------------------------
  // Synchroniser; the first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // A new level must hold for the whole window; shorter pulses vanish
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinOut_q    <= 1'b1;
      stableCnt_q <= '0;
    end else if (sync2_q == pinOut_q) begin
      stableCnt_q <= '0;
    end else if (stableCnt_q == FILT_LAST) begin
      pinOut_q    <= sync2_q;
      stableCnt_q <= '0;
    end else begin
      stableCnt_q <= stableCnt_q + 1'b1;
    end
  end

endmodule

/* File: hdl/tw_eeprom_target.sv */
// Two-wire serial memory target: protocol engine, page buffer and array
//
// Function
// R1: Data changes only with clock low; changes with clock high are start/stop.
// R2: Data falling while clock high is start; address reception begins.
// R3: Data rising while clock high is stop; device returns to standby.
// R4: Words are eight bits MSB first; receiver acknowledges low on ninth clock.
// R5: Standby at power-up and after stop once internal write finishes.
// R6: Host recovers bus with up to nine clocks then a start.
// R7: Device address word starts with fixed one-zero-one-zero pattern.
// R8: Smallest sizes compare next three bits with the three select pins.
// R9: Larger sizes use non-pin selection bits as upper word address bits.
// R10: Address word LSB selects direction: one reads, zero writes.
// R11: Matching address is acknowledged; mismatch gets no acknowledge, idle till start.
// R12: Write sends word address then data; each acknowledged; stop ends it.
// R13: Stop after write launches self-timed write; inputs ignored until done.
// R14: Page write buffers eight or sixteen bytes by array size.
// R15: Every page data byte is acknowledged; stop launches programming.
// R16: Only low page bits advance and wrap; upper address bits stay.
// R17: Address polling is acknowledged only after the write cycle ends.
// R18: Address counter holds last accessed location plus one for current reads.
// R19: Random read uses dummy write, repeated start, then read address.
// R20: Host acknowledge continues sequential read; no acknowledge and stop end it.
// R21: Read address wraps from last array byte to first.
// R22: Device only pulls data low or releases it, never drives high.
// R23: Clock and data are synchronised and filtered before edge detection.
`timescale 1ns/1ps
module tw_eeprom_target
  import tw_pkg::*;
#(
  parameter int SIZE_CODE   = SIZE_16K,
  parameter int WR_CYCLES_P = WR_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  input  wire logic selectPinHigh,
  input  wire logic selectPinMid,
  input  wire logic selectPinLow,
  output logic      sdaOut_q,
  output logic      sdaOeN_q,
  output logic      standby_q,
  output logic      writeBusy_q
);

  localparam int                PAGE_BITS = twPageBits(SIZE_CODE);
  localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'((1 << twAddrBits(SIZE_CODE)) - 1);
  localparam logic [ADDR_W-1:0] LOW_MASK  = ADDR_W'((1 << twLowBits(SIZE_CODE)) - 1);
  localparam logic [BUSY_W-1:0] WR_LAST   = BUSY_W'(WR_CYCLES_P - 1);

  logic              sclF;
  logic              sdaF;
  logic              sclP_q;
  logic              sdaP_q;
  logic [2:0]        pinS1_q;
  logic [2:0]        pinS2_q;
  tw_state_t         state_q;
  tw_state_t         next_q;
  logic [3:0]        bitCnt_q;
  logic              ackPh_q;
  logic [7:0]        shift_q;
  logic [7:0]        rdShift_q;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0]        page_q;
  logic [BUSY_W-1:0] busyCnt_q;
  logic [ADDR_W-1:0] row_q;
  logic [7:0]        mem [0:MEM_BYTES-1];
  logic [7:0]        pgData [0:PAGE_MAX-1];
  logic [PAGE_MAX-1:0] pgValid_q;
  logic [11:0]       fifo [0:FIFO_DEPTH-1];
  logic              fWr_q;
  logic              fRd_q;
  logic [1:0]        fCnt_q;

  // Byte increment with a wrap mask
  function automatic logic [ADDR_W-1:0] incWithin(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] m);
    return (a & ~m) | ((a + 11'h001) & m);
  endfunction

  // Pin compare on selection bits not taken as page bits
  function automatic logic pinMatch(input logic [2:0] got, input logic [2:0] pins);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (i >= PAGE_BITS && got[i] != pins[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Pin conditioning and bus events
  // ----------------------------------------------------------------
  tw_pin_filter u_sclFilt (.mclk(mclk), .rst(rst), .pinIn(sclIn), .pinOut_q(sclF)); // [R23]
  tw_pin_filter u_sdaFilt (.mclk(mclk), .rst(rst), .pinIn(sdaIn), .pinOut_q(sdaF)); // [R23]

  // Select pins are static straps but still cross into this domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1_q <= 3'h0;
      pinS2_q <= 3'h0;
      sclP_q  <= 1'b1;
      sdaP_q  <= 1'b1;
    end else begin
      pinS1_q <= {selectPinHigh, selectPinMid, selectPinLow};
      pinS2_q <= pinS1_q;
      sclP_q  <= sclF;
      sdaP_q  <= sdaF;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic decide;
  logic devMatch;
  logic push;
  logic pop;
  logic anyData;
  logic launch;
  logic commit;
  logic [7:0] memRd;

  // Data edges under a high clock are framing, never data bits
  assign sclRise  = sclF & ~sclP_q;
  assign sclFall  = ~sclF & sclP_q;
  assign startEv  = sclF & sclP_q & sdaP_q & ~sdaF; // [R1] [R2]
  assign stopEv   = sclF & sclP_q & ~sdaP_q & sdaF; // [R1] [R3]
  assign decide   = sclFall & (bitCnt_q == BIT_ACK) & ~ackPh_q &
                    (state_q inside {ST_DEV, ST_WADDR, ST_WDATA});
  // Busy device answers no address, so polling sees no acknowledge
  assign devMatch = (shift_q[7:4] == DEV_TYPE_CODE) & pinMatch(shift_q[3:1], pinS2_q) &
                    ~writeBusy_q; // [R7] [R8] [R9] [R17]
  assign push     = decide & (state_q == ST_WDATA) & (fCnt_q != 2'h2);
  assign pop      = (fCnt_q != 2'h0) & ~writeBusy_q;
  assign anyData  = (pgValid_q != '0) | (fCnt_q != 2'h0);
  assign launch   = stopEv & ~writeBusy_q & (state_q == ST_WDATA) & anyData; // [R13] [R15]
  assign commit   = writeBusy_q & (busyCnt_q == WR_LAST);
  assign memRd    = mem[addr_q];

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // Acknowledge is decided at the fall after bit eight, released at the next
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      next_q    <= ST_IDLE;
      bitCnt_q  <= 4'h0;
      ackPh_q   <= 1'b0;
      shift_q   <= 8'h00;
      rdShift_q <= 8'hff;
      addr_q    <= '0;
      page_q    <= 3'h0;
      sdaOeN_q  <= 1'b1;
    end else if (startEv) begin
      state_q  <= ST_DEV; // [R2]
      bitCnt_q <= 4'h0;
      ackPh_q  <= 1'b0;
      sdaOeN_q <= 1'b1;
    end else if (stopEv) begin
      state_q  <= ST_IDLE; // [R3]
      ackPh_q  <= 1'b0;
      sdaOeN_q <= 1'b1;
    end else if (state_q != ST_IDLE) begin
      if (sclRise) begin
        if (bitCnt_q == BIT_ACK) begin
          bitCnt_q <= 4'h0;
          if (state_q == ST_READ && !ackPh_q) begin
            if (sdaF) begin
              state_q <= ST_IDLE; // [R20]
            end else begin
              rdShift_q <= memRd; // [R20]
              addr_q    <= incWithin(addr_q, ADDR_MASK); // [R18] [R21]
            end
          end
        end else begin
          bitCnt_q  <= bitCnt_q + 4'h1;
          shift_q   <= {shift_q[6:0], sdaF}; // [R4]
          rdShift_q <= {rdShift_q[6:0], 1'b1};
        end
      end else if (sclFall) begin
        if (ackPh_q) begin
          ackPh_q  <= 1'b0;
          state_q  <= next_q;
          sdaOeN_q <= (next_q == ST_READ) ? rdShift_q[7] : 1'b1; // [R22]
        end else if (state_q == ST_READ) begin
          // Release for the host's acknowledge slot
          sdaOeN_q <= (bitCnt_q == BIT_ACK) ? 1'b1 : rdShift_q[7]; // [R4] [R22]
        end else if (decide) begin
          case (state_q)
            ST_DEV: begin
              if (devMatch) begin
                ackPh_q  <= 1'b1;
                sdaOeN_q <= 1'b0; // [R11]
                page_q   <= shift_q[3:1]; // [R9]
                if (shift_q[0]) begin
                  next_q    <= ST_READ; // [R10]
                  rdShift_q <= memRd; // [R18]
                  addr_q    <= incWithin(addr_q, ADDR_MASK); // [R21]
                end else begin
                  next_q <= ST_WADDR; // [R10]
                end
              end else begin
                state_q <= ST_IDLE; // [R11]
              end
            end
            ST_WADDR: begin
              ackPh_q  <= 1'b1;
              sdaOeN_q <= 1'b0; // [R12]
              addr_q   <= {page_q, shift_q} & ADDR_MASK; // [R9]
              next_q   <= ST_WDATA;
            end
            default: begin
              if (push) begin
                ackPh_q  <= 1'b1;
                sdaOeN_q <= 1'b0; // [R15]
                addr_q   <= incWithin(addr_q, LOW_MASK); // [R16]
                next_q   <= ST_WDATA;
              end else begin
                // Buffer full: refuse the byte rather than lose it
                state_q <= ST_IDLE;
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry byte buffer between bus and page latch
  // ----------------------------------------------------------------
  // Drain stalls during the write cycle; a full buffer refuses the byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fWr_q  <= 1'b0;
      fRd_q  <= 1'b0;
      fCnt_q <= 2'h0;
    end else begin
      if (push) begin
        fifo[fWr_q] <= {addr_q[3:0], shift_q}; // [R14]
        fWr_q       <= ~fWr_q;
      end
      if (pop) begin
        fRd_q <= ~fRd_q;
      end
      fCnt_q <= fCnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Page latch
  // ----------------------------------------------------------------
  // Repeated start abandons an unfinished page; later bytes overwrite
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pgValid_q <= '0;
    end else if (commit || (startEv && !writeBusy_q)) begin
      pgValid_q <= '0;
    end else if (pop) begin
      pgData[fifo[fRd_q][11:8] & LOW_MASK[3:0]]    <= fifo[fRd_q][7:0]; // [R14] [R16]
      pgValid_q[fifo[fRd_q][11:8] & LOW_MASK[3:0]] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      writeBusy_q <= 1'b0;
      busyCnt_q   <= '0;
      row_q       <= '0;
    end else if (launch) begin
      writeBusy_q <= 1'b1; // [R13]
      busyCnt_q   <= '0;
      row_q       <= addr_q & ~LOW_MASK; // [R16]
    end else if (commit) begin
      writeBusy_q <= 1'b0;
    end else if (writeBusy_q) begin
      busyCnt_q <= busyCnt_q + 1'b1;
    end
  end

  // Array updated at the end of the cycle; until then every poll is refused, so nothing reads it
  always_ff @(posedge mclk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_MAX; i++) begin
        if (pgValid_q[i]) begin
          mem[row_q | ADDR_W'(i)] <= pgData[i]; // [R13]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and standby
  // ----------------------------------------------------------------
  // Output level is held low; only the enable moves
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdaOut_q  <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      sdaOut_q  <= 1'b0; // [R22]
      standby_q <= (state_q == ST_IDLE) & ~writeBusy_q; // [R5]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sDevDecide;
    decide && state_q == ST_DEV;
  endsequence

  sequence sPageByte;
    push ##0 sclFall;
  endsequence

  a_addr_match_ack: assert property (sDevDecide ##0 devMatch |=> !sdaOeN_q) // [R11]
    else $error("matching address not acknowledged");
  a_addr_miss_idle: assert property (sDevDecide ##0 !devMatch |=> (state_q == ST_IDLE)
    && sdaOeN_q) // [R11]
    else $error("mismatched address not refused");
  a_start_enters: assert property (startEv |=> state_q == ST_DEV && bitCnt_q == 4'h0) // [R2]
    else $error("start did not begin address reception");
  a_stop_idle: assert property (stopEv |=> state_q == ST_IDLE && sdaOeN_q) // [R3]
    else $error("stop did not return to idle");
  a_busy_silent: assert property (writeBusy_q |-> sdaOeN_q) // [R17]
    else $error("device answered during write cycle");
  a_write_launch: assert property (launch |=> writeBusy_q && busyCnt_q == '0) // [R13]
    else $error("stop after write did not start write cycle");
  a_busy_length: assert property ($fell(writeBusy_q) |-> $past(busyCnt_q) == WR_LAST) // [R13]
    else $error("write cycle length wrong");
  a_page_row_kept: assert property (sPageByte |=> (addr_q & ~LOW_MASK) ==
    $past(addr_q & ~LOW_MASK)) // [R16]
    else $error("page row changed during page write");
  a_standby_entry: assert property (state_q == ST_IDLE && !writeBusy_q |=> standby_q) // [R5]
    else $error("standby not entered");
  a_pull_low_only: assert property (!sdaOeN_q |-> !sdaOut_q) // [R22]
    else $error("data line driven high");

endmodule

/* File: verif/tw_host_model.sv */
// Host bus controller model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module tw_host_model (
  input  wire logic       mclk,
  input  wire logic       sdaLine,
  output logic            sclOut,
  output logic            sdaPull,
  output logic [8:0]      resVal,
  output logic            resStrobe
);
  // ----------------------------------------------------------------
  // Bus phases, paced on the falling system clock edge
  // ----------------------------------------------------------------
  // Bus idle: clock high, line released to the pull-up
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
    resVal = 9'h000;
    resStrobe = 1'b0;
  end

  task automatic waitCyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Data moves mid-low, three cycles clear of both clock edges
  task automatic bitSlot(input logic b, output logic got);
    waitCyc(3);
    sdaPull = ~b;
    waitCyc(3);
    sclOut = 1'b1;
    waitCyc(3);
    got = sdaLine;
    waitCyc(3);
    sclOut = 1'b0;
  endtask

  // Also serves as repeated start, so the line is released first
  task automatic startCond();
    waitCyc(3);
    sdaPull = 1'b0;
    waitCyc(3);
    sclOut = 1'b1;
    waitCyc(6);
    sdaPull = 1'b1;
    waitCyc(6);
    sclOut = 1'b0;
  endtask

  task automatic stopCond();
    waitCyc(3);
    sdaPull = 1'b1;
    waitCyc(3);
    sclOut = 1'b1;
    waitCyc(6);
    sdaPull = 1'b0;
    waitCyc(6);
  endtask

  task automatic report(input logic [8:0] v);
    resVal = v;
    resStrobe = 1'b1;
    waitCyc(1);
    resStrobe = 1'b0;
  endtask

  // Eight bits MSB first plus the ninth slot; reports what the line carried
  task automatic word(input logic [7:0] tx, input logic ninth);
    logic [8:0] got;
    for (int i = 8; i >= 0; i--) begin
      bitSlot((i > 0) ? tx[i-1] : ninth, got[i]);
    end
    report(got);
  endtask

  // Nine released clocks; any low level seen while clock high is reported
  task automatic recover();
    logic got;
    logic anyLow;
    anyLow = 1'b0;
    for (int i = 0; i < 9; i++) begin
      bitSlot(1'b1, got);
      anyLow = anyLow | ~got;
    end
    report({8'h00, anyLow});
  endtask
endmodule

/* File: verif/two_wire_eeprom_target_protocol_bench.sv */
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ps
module two_wire_eeprom_target_protocol_bench
  import tw_pkg::*;
;
  // ----------------------------------------------------------------
  // 4K size: two pins compared, one page bit, short write time
  // ----------------------------------------------------------------
  localparam int WRC = 200;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        pinHigh = 1'b1;
  logic        pinMid = 1'b0;
  logic        pinLow = 1'b1;   // No-connect here, must be ignored
  logic        sclOut;
  logic        sdaPull;
  logic        sdaLine;
  logic        resStrobe;
  logic [8:0]  resVal;
  logic        sdaOut;
  logic        sdaOeN;
  logic        standby;
  logic        writeBusy;
  logic [7:0]  mem [0:511];
  logic [8:0]  expQ [$];
  logic [8:0]  rdAddr;
  logic [15:0] lfsr = 16'hdf5c;   // Seed 57180
  logic [7:0]  badDev [3] = '{8'h28, 8'ha0, 8'hac};   // Bad code, bad high pin, bad mid pin
  int          failures = 0;
  int          numChecks = 0;
  int          cycles = 0;
  int          busyRun = 0;
  int          lastLen = 0;

  always #2 mclk = ~mclk;
  // Open-drain line with pull-up
  assign sdaLine = ~(sdaPull | (~sdaOeN & ~sdaOut));

  tw_eeprom_target #(.SIZE_CODE(SIZE_4K), .WR_CYCLES_P(WRC)) tw_eeprom_target_inst (
    .mclk(mclk), .rst(rst), .sclIn(sclOut), .sdaIn(sdaLine), .selectPinHigh(pinHigh),
    .selectPinMid(pinMid), .selectPinLow(pinLow), .sdaOut_q(sdaOut), .sdaOeN_q(sdaOeN),
    .standby_q(standby), .writeBusy_q(writeBusy));
  tw_host_model tw_host_model_inst (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclOut),
    .sdaPull(sdaPull), .resVal(resVal), .resStrobe(resStrobe));

  task automatic check(input string what, input logic [8:0] expV, input logic [8:0] got);
    numChecks++;
    if (got !== expV) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, expV, got);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] nextLfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] dev(input logic pg, input logic rd);
    return {4'ha, pinHigh, pinMid, pg, rd};
  endfunction

  task automatic xw(input logic [7:0] b, input logic ninth, input logic [8:0] expV);
    expQ.push_back(expV);
    tw_host_model_inst.word(b, ninth);
  endtask

  // Oldest note against each word seen on the line
  always @(posedge mclk) begin
    if (resStrobe) begin
      if (expQ.size() == 0) check("unexpected word", 9'h000, 9'h1ff);
      else check("line word", expQ.pop_front(), resVal);
    end
  end

  // Hang guard and measured length of each write cycle
  // Sampled mid-cycle, away from the edge that moves the busy flag
  always @(negedge mclk) begin
    cycles <= cycles + 1;
    if (writeBusy) begin
      busyRun <= busyRun + 1;
    end else begin
      if (busyRun != 0) lastLen <= busyRun;
      busyRun <= 0;
    end
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // The pin may only pull low
  always @(negedge mclk) begin
    if (sdaOeN === 1'b0) check("pin level", 9'h000, {8'h00, sdaOut});
  end

  // Poll while busy must be refused; then the full cycle is timed
  task automatic waitWrite(input logic [7:0] d);
    int n;
    n = 0;
    while (writeBusy !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check("busy after stop", 9'h001, {8'h00, writeBusy});
    tw_host_model_inst.startCond();
    xw(d, 1'b1, {d, 1'b1});
    tw_host_model_inst.stopCond();
    n = 0;
    while (writeBusy !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    check("write time", 9'h001, {8'h00, lastLen >= WRC && lastLen <= WRC + 1});
    check("standby after write", 9'h001, {8'h00, standby});
    // Poll again once idle: now the address must be taken
    tw_host_model_inst.startCond();
    xw(d, 1'b1, {d, 1'b0});
    tw_host_model_inst.stopCond();
  endtask

  // Random bytes; low four address bits wrap inside the page
  task automatic pageWrite(input logic [8:0] addr, input int n);
    logic [8:0] a;
    logic [7:0] d;
    a = addr;
    tw_host_model_inst.startCond();
    xw(dev(addr[8], 1'b0), 1'b1, {dev(addr[8], 1'b0), 1'b0});
    xw(addr[7:0], 1'b1, {addr[7:0], 1'b0});
    for (int i = 0; i < n; i++) begin
      lfsr = nextLfsr(lfsr);
      d = lfsr[7:0];
      mem[a] = d;
      xw(d, 1'b1, {d, 1'b0});
      a = {a[8:4], a[3:0] + 4'h1};
    end
    tw_host_model_inst.stopCond();
    waitWrite(dev(addr[8], 1'b0));
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    check("standby at reset", 9'h001, {8'h00, standby});
    check("busy at reset", 9'h000, {8'h00, writeBusy});
    // Refused addresses; the last is left hanging for recovery
    foreach (badDev[k]) begin
      tw_host_model_inst.startCond();
      xw(badDev[k], 1'b1, {badDev[k], 1'b1});
      repeat (8) @(negedge mclk);
      check("standby after refusal", 9'h001, {8'h00, standby});
      if (k < 2) tw_host_model_inst.stopCond();
    end
    expQ.push_back(9'h000);
    tw_host_model_inst.recover();
    pageWrite(9'h1f4, 18);
    pageWrite(9'h000, 2);
    // Random read over the array top, ending with no acknowledge
    tw_host_model_inst.startCond();
    xw(dev(1'b1, 1'b0), 1'b1, {dev(1'b1, 1'b0), 1'b0});
    xw(8'hf4, 1'b1, 9'h1e8);
    tw_host_model_inst.startCond();
    xw(dev(1'b1, 1'b1), 1'b1, {dev(1'b1, 1'b1), 1'b0});
    for (int i = 0; i < 13; i++) begin
      rdAddr = 9'h1f4 + 9'(i);
      xw(8'hff, 1'(i == 12), {mem[rdAddr], 1'(i == 12)});
    end
    tw_host_model_inst.stopCond();
    repeat (8) @(negedge mclk);
    check("standby after read", 9'h001, {8'h00, standby});
    tw_host_model_inst.startCond();
    xw(dev(1'b0, 1'b1), 1'b1, {dev(1'b0, 1'b1), 1'b0});
    xw(8'hff, 1'b1, {mem[9'h001], 1'b1});
    tw_host_model_inst.stopCond();
    repeat (8) @(negedge mclk);
    check("words left", 9'h000, 9'(expQ.size()));
    stop_test();
  end
endmodule
